// [core/serial_dma_status.sv]
// dual-buffer dma status, transmit addressing and avalon register slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module serial_dma_status (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic [31:0]               avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic [31:0]                    avs_readdata,
   output logic                           avs_waitrequest,
   output logic                           irq,
   input  wire logic                      rx_byte_valid,
   input  wire logic                      rx_byte_parity_err,
   output logic                           rx_byte_ready,
   input  wire logic                      rx_fifo_full,
   input  wire logic                      rx_buf_end,
   output logic                           mem_rd_req,
   output logic [dma_pkg::ADDR_W-1:0]     mem_rd_addr,
   input  wire logic                      mem_rd_ack,
   input  wire logic [7:0]                mem_rd_data,
   output logic [7:0]                     tx_data,
   output logic                           tx_data_valid,
   input  wire logic                      tx_data_ready
);
   import dma_pkg::*;

   typedef struct packed {
      logic                ack;
      logic [31:0]         rdata;
      logic [ADDR_W-1:0]   a_start;
      logic [ADDR_W-1:0]   a_last;
      logic [ADDR_W-1:0]   b_start;
      logic [ADDR_W-1:0]   b_last;
      logic                tx_a_load;
      logic                tx_b_load;
      logic                tx_run;
      logic                tx_sel;
      logic                tx_go;
      logic                tx_clr;
      logic                rx_a_load;
      logic                rx_b_load;
      logic                rx_sel;
      logic                a_par;
      logic                b_par;
      logic                a_ovr;
      logic                b_ovr;
      logic                ovr_pend;
      logic                ovr_tgt_ok;
      logic                ovr_tgt;
      logic [IRQ_W-1:0]    irq_st;
      logic [IRQ_W-1:0]    irq_mask;
      logic                uart;
   } core_t;

   core_t q;
   core_t d;

   logic [ADDR_W-1:0] tx_offset;
   logic              tx_done;
   logic              req;
   logic              take;
   logic              wr;
   logic              rd;
   logic [31:0]       rmux;
   logic [7:0]        bstate;
   logic              rx_take;
   logic              rx_cur_b;
   logic [IRQ_W-1:0]  ev;

   // byte-enabled write of a 14-bit field
   function automatic logic [ADDR_W-1:0] merge14(input logic [ADDR_W-1:0] old,
                                                  input logic [31:0]       wd,
                                                  input logic [3:0]        be);
      logic [ADDR_W-1:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[13:8] = wd[13:8];
      end
      return r;
   endfunction

   // address match for one register
   function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
      return (a == ofs);
   endfunction

   // bus handshake: answer one cycle after request
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~q.ack;
   assign take            = req & q.ack;
   assign wr              = take & avs_write;
   assign rd              = take & avs_read;
   assign avs_readdata    = q.rdata;
   assign irq             = |(q.irq_st & q.irq_mask);

   // receive side: current buffer and byte acceptance
   assign rx_cur_b      = q.rx_sel;
   assign rx_byte_ready = q.rx_a_load | q.rx_b_load;
   assign rx_take       = rx_byte_valid & rx_byte_ready;

   // R05: tx active flags
   // R06: rx active flags
   always_comb begin
      bstate              = 8'h00;
      bstate[BS_RX_A_ACT] = q.rx_a_load & ~rx_cur_b;
      bstate[BS_RX_B_ACT] = q.rx_b_load & rx_cur_b;
      bstate[BS_TX_A_ACT] = q.tx_run & ~q.tx_sel;
      bstate[BS_TX_B_ACT] = q.tx_run & q.tx_sel;
      bstate[BS_RX_A_OVR] = q.a_ovr;
      bstate[BS_RX_B_OVR] = q.b_ovr;
      bstate[BS_RX_A_PAR] = q.a_par;
      bstate[BS_RX_B_PAR] = q.b_par;
   end

   // read multiplexer, unmapped reads give zero
   always_comb begin
      rmux = 32'h00000000;
      // R09: fixed upper bits on address registers
      if (hit(avs_address, TX_A_START_OFS)) begin
         rmux = TX_ADDR_FIXED | {18'h0, q.a_start};
      end else if (hit(avs_address, TX_A_LAST_OFS)) begin
         rmux = TX_ADDR_FIXED | {18'h0, q.a_last};
      end else if (hit(avs_address, TX_B_START_OFS)) begin
         rmux = TX_ADDR_FIXED | {18'h0, q.b_start};
      end else if (hit(avs_address, TX_B_LAST_OFS)) begin
         rmux = TX_ADDR_FIXED | {18'h0, q.b_last};
      end else if (hit(avs_address, TX_OFFSET_OFS)) begin
         // R11: zero from load write until the buffer runs
         rmux = (q.tx_run & ~q.tx_go) ? {18'h0, tx_offset} : 32'h0;
      end else if (hit(avs_address, BUF_STATE_OFS)) begin
         rmux = {24'h0, bstate};
      end else if (hit(avs_address, CTRL_OFS)) begin
         // R13: load bits read back as pending or active
         rmux = {28'h0, q.tx_b_load, q.tx_a_load, q.rx_b_load, q.rx_a_load};
      end else if (hit(avs_address, IRQ_STATUS_OFS)) begin
         rmux = {26'h0, q.irq_st};
      end else if (hit(avs_address, IRQ_MASK_OFS)) begin
         rmux = {26'h0, q.irq_mask};
      end else if (hit(avs_address, CONFIG_OFS)) begin
         rmux = {31'h0, q.uart};
      end
   end

   // next state of registers, buffers and flags
   always_comb begin
      logic ctl_wr;
      logic rx_rst;
      logic tx_rst;
      logic set_ra;
      logic set_rb;
      logic set_ta;
      logic set_tb;
      ctl_wr = wr & hit(avs_address, CTRL_OFS) & avs_byteenable[0];
      rx_rst = ctl_wr & avs_writedata[CTRL_RX_RST];
      tx_rst = ctl_wr & avs_writedata[CTRL_TX_RST];
      set_ra = ctl_wr & avs_writedata[CTRL_RX_A_LOAD];
      set_rb = ctl_wr & avs_writedata[CTRL_RX_B_LOAD];
      set_ta = ctl_wr & avs_writedata[CTRL_TX_A_LOAD];
      set_tb = ctl_wr & avs_writedata[CTRL_TX_B_LOAD];
      ev     = '0;
      d      = q;
      d.ack  = req & ~q.ack;
      if (avs_read & ~q.ack) begin
         d.rdata = rmux;
      end
      // R07: start address fields
      if (wr & hit(avs_address, TX_A_START_OFS)) begin
         d.a_start = merge14(q.a_start, avs_writedata, avs_byteenable);
      end
      if (wr & hit(avs_address, TX_B_START_OFS)) begin
         d.b_start = merge14(q.b_start, avs_writedata, avs_byteenable);
      end
      // R08: last byte address fields
      if (wr & hit(avs_address, TX_A_LAST_OFS)) begin
         d.a_last = merge14(q.a_last, avs_writedata, avs_byteenable);
      end
      if (wr & hit(avs_address, TX_B_LAST_OFS)) begin
         d.b_last = merge14(q.b_last, avs_writedata, avs_byteenable);
      end
      if (wr & hit(avs_address, IRQ_MASK_OFS) & avs_byteenable[0]) begin
         d.irq_mask = avs_writedata[IRQ_W-1:0];
      end
      if (wr & hit(avs_address, CONFIG_OFS) & avs_byteenable[0]) begin
         d.uart = avs_writedata[CFG_UART];
      end

      // transmit buffer sequencing
      d.tx_go  = 1'b0;
      d.tx_clr = tx_rst;
      // R13: completion clears the load bit
      if (tx_done & q.tx_run) begin
         d.tx_run = 1'b0;
         if (q.tx_sel) begin
            d.tx_b_load       = 1'b0;
            ev[IRQ_TX_B_DONE] = 1'b1;
         end else begin
            d.tx_a_load       = 1'b0;
            ev[IRQ_TX_A_DONE] = 1'b1;
         end
      end
      // R12: buffer a wins when both wait
      if (~q.tx_run & ~q.tx_go & (q.tx_a_load | q.tx_b_load)) begin
         d.tx_sel = ~q.tx_a_load;
         d.tx_run = 1'b1;
         d.tx_go  = 1'b1;
      end
      // R13: writing one loads, zero ignored
      if (set_ta) begin
         d.tx_a_load = 1'b1;
      end
      if (set_tb) begin
         d.tx_b_load = 1'b1;
      end
      // R14: transmit reset, bit not stored
      if (tx_rst) begin
         d.tx_a_load = 1'b0;
         d.tx_b_load = 1'b0;
         d.tx_run    = 1'b0;
         d.tx_go     = 1'b0;
      end

      // receive buffer sequencing
      if (rx_buf_end & rx_byte_ready) begin
         if (rx_cur_b) begin
            d.rx_b_load       = 1'b0;
            ev[IRQ_RX_B_DONE] = 1'b1;
         end else begin
            d.rx_a_load       = 1'b0;
            ev[IRQ_RX_A_DONE] = 1'b1;
         end
         d.rx_sel = ~q.rx_sel;
      end
      // R12: from idle, a is taken first
      if (~rx_byte_ready & (set_ra | set_rb)) begin
         d.rx_sel = ~set_ra;
      end
      // R02: overrun held while nothing is loaded
      if (~rx_byte_ready & rx_fifo_full) begin
         d.ovr_pend = 1'b1;
      end
      // R02: the next loaded buffer is the target
      if ((q.ovr_pend | (~rx_byte_ready & rx_fifo_full)) & ~q.ovr_tgt_ok & ~rx_byte_ready
          & (set_ra | set_rb)) begin
         d.ovr_tgt_ok = 1'b1;
         d.ovr_tgt    = ~set_ra;
      end
      // flags clear when their buffer is loaded again
      if (set_ra) begin
         d.rx_a_load = 1'b1;
         d.a_par     = 1'b0;
         d.a_ovr     = 1'b0;
      end
      if (set_rb) begin
         d.rx_b_load = 1'b1;
         d.b_par     = 1'b0;
         d.b_ovr     = 1'b0;
      end
      // R01: parity flag in uart mode only
      if (rx_take & rx_byte_parity_err & q.uart) begin
         ev[IRQ_PARITY] = 1'b1;
         if (rx_cur_b) begin
            d.b_par = 1'b1;
         end else begin
            d.a_par = 1'b1;
         end
      end
      // R03: b takes the pending overrun
      // R04: a takes the pending overrun
      if (rx_take & q.ovr_pend & q.ovr_tgt_ok & (q.ovr_tgt == rx_cur_b)) begin
         ev[IRQ_OVERRUN] = 1'b1;
         d.ovr_pend      = 1'b0;
         d.ovr_tgt_ok    = 1'b0;
         if (rx_cur_b) begin
            d.b_ovr = 1'b1;
         end else begin
            d.a_ovr = 1'b1;
         end
      end
      // R14: receive reset, bit not stored
      if (rx_rst) begin
         d.rx_a_load  = 1'b0;
         d.rx_b_load  = 1'b0;
         d.rx_sel     = 1'b0;
         d.a_par      = 1'b0;
         d.b_par      = 1'b0;
         d.a_ovr      = 1'b0;
         d.b_ovr      = 1'b0;
         d.ovr_pend   = 1'b0;
         d.ovr_tgt_ok = 1'b0;
      end

      // sticky events; a read clears only what it returned, set wins
      if (rd & hit(avs_address, IRQ_STATUS_OFS)) begin
         d.irq_st = q.irq_st & ~q.rdata[IRQ_W-1:0];
      end
      d.irq_st = d.irq_st | ev;
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q          <= '0;
         q.a_start  <= TX_ADDR_RESET;
         q.a_last   <= TX_ADDR_RESET;
         q.b_start  <= TX_ADDR_RESET;
         q.b_last   <= TX_ADDR_RESET;
         q.irq_st   <= IRQ_RESET;
         q.irq_mask <= IRQ_RESET;
      end else begin
         q <= d;
      end
   end

   // transmit fetch engine, started per buffer
   tx_fetch u_fetch (
      .clk           (clk),
      .rstn          (rstn),
      .clear         (q.tx_clr),
      .start         (q.tx_go),
      .base          (q.tx_sel ? q.b_start : q.a_start),
      .last          (q.tx_sel ? q.b_last : q.a_last),
      .mem_rd_req    (mem_rd_req),
      .mem_rd_addr   (mem_rd_addr),
      .mem_rd_ack    (mem_rd_ack),
      .mem_rd_data   (mem_rd_data),
      .tx_data       (tx_data),
      .tx_data_valid (tx_data_valid),
      .tx_data_ready (tx_data_ready),
      .done          (tx_done),
      .offset        (tx_offset)
   );
endmodule

// [core/tx_fetch.sv]
// transmit byte fetch engine with offset counter
`timescale 1ns/10ps
module tx_fetch (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      clear,
   input  wire logic                      start,
   input  wire logic [dma_pkg::ADDR_W-1:0] base,
   input  wire logic [dma_pkg::ADDR_W-1:0] last,
   output logic                           mem_rd_req,
   output logic [dma_pkg::ADDR_W-1:0]     mem_rd_addr,
   input  wire logic                      mem_rd_ack,
   input  wire logic [7:0]                mem_rd_data,
   output logic [7:0]                     tx_data,
   output logic                           tx_data_valid,
   input  wire logic                      tx_data_ready,
   output logic                           done,
   output logic [dma_pkg::ADDR_W-1:0]     offset
);
   import dma_pkg::*;

   typedef struct packed {
      fetch_state_t        st;
      logic [ADDR_W-1:0]   base;
      logic [ADDR_W-1:0]   last;
      logic [ADDR_W-1:0]   ofs;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          data;
      logic                valid;
      logic                done;
   } fetch_t;

   fetch_t q;
   fetch_t d;

   // next-state of the fetch sequence
   always_comb begin
      d       = q;
      d.valid = 1'b0;
      d.done  = 1'b0;
      unique case (q.st)
         FETCH_IDLE: begin
         end
         FETCH_ASK: begin
            // R15: request start plus offset
            if (tx_data_ready) begin
               d.addr = q.base + q.ofs;
               d.st   = FETCH_WAIT;
            end
         end
         FETCH_WAIT: begin
            if (mem_rd_ack) begin
               d.data  = mem_rd_data;
               d.valid = 1'b1;
               // R15: stop after the last byte
               if (q.addr == q.last) begin
                  d.done = 1'b1;
                  d.st   = FETCH_IDLE;
               end else begin
                  d.ofs = q.ofs + 14'h0001;
                  d.st  = FETCH_ASK;
               end
            end
         end
      endcase
      // R11: offset cleared on buffer load
      if (start) begin
         d.base = base;
         d.last = last;
         d.ofs  = '0;
         d.st   = FETCH_ASK;
      end
      // R11: offset cleared on dma reset
      if (clear) begin
         d.ofs = '0;
         d.st  = FETCH_IDLE;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '{st: FETCH_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign mem_rd_req    = (q.st == FETCH_WAIT);
   assign mem_rd_addr   = q.addr;
   assign tx_data       = q.data;
   assign tx_data_valid = q.valid;
   assign done          = q.done;
   // R10: offset of next byte
   assign offset        = q.ofs;
endmodule

// [pkg/dma_pkg.sv]
// constants and types of the serial dual-buffer dma status block
// Overview of operation
// R01: in uart mode a parity-marked byte into rx buffer a sets its parity flag
// R02: overrun with no rx buffer loaded is held and passed to the next loaded buffer
// R03: buffer b overrun flag set when b takes pending overrun; cleared on load or reset
// R04: buffer a overrun flag set when a takes pending overrun; cleared on load or reset
// R05: read-only flags show transmit buffer b or a as the active one
// R06: read-only flags show receive buffer b or a as the active one
// R07: each transmit buffer has a 14-bit writable start address
// R08: each transmit buffer has a 14-bit writable address of its final byte
// R09: tx address registers reset to 0x20000000, bit 29 fixed one, others zero
// R10: read-only 14-bit offset to next byte fetched from active tx buffer
// R11: tx offset clears when a tx buffer is loaded and on tx dma reset
// R12: buffers a and b loaded together are processed a first, then b
// R13: writing one loads a buffer, zero does nothing; cleared when its dma completes
// R14: writing one to a dma reset bit resets that direction; bit self-clears
// R15: tx engine fetches start plus offset up to last byte, then switches buffer
package dma_pkg;
   localparam int          ADDR_W          = 14;
   localparam int          IRQ_W           = 6;
   // register byte addresses
   localparam logic [31:0] TX_A_START_OFS  = 32'h4000c810;
   localparam logic [31:0] TX_A_LAST_OFS   = 32'h4000c814;
   localparam logic [31:0] TX_B_START_OFS  = 32'h4000c818;
   localparam logic [31:0] TX_B_LAST_OFS   = 32'h4000c81c;
   localparam logic [31:0] TX_OFFSET_OFS   = 32'h4000c828;
   localparam logic [31:0] BUF_STATE_OFS   = 32'h4000c82c;
   localparam logic [31:0] CTRL_OFS        = 32'h4000c830;
   localparam logic [31:0] IRQ_STATUS_OFS  = 32'h4000c834;
   localparam logic [31:0] IRQ_MASK_OFS    = 32'h4000c838;
   localparam logic [31:0] CONFIG_OFS      = 32'h4000c83c;
   // reset values
   localparam logic [31:0] TX_ADDR_FIXED   = 32'h20000000;
   localparam logic [13:0] TX_ADDR_RESET   = 14'h0000;
   localparam logic [5:0]  IRQ_RESET       = 6'h00;
   // buffer state bits
   localparam int          BS_RX_A_ACT     = 0;
   localparam int          BS_RX_B_ACT     = 1;
   localparam int          BS_TX_A_ACT     = 2;
   localparam int          BS_TX_B_ACT     = 3;
   localparam int          BS_RX_A_OVR     = 4;
   localparam int          BS_RX_B_OVR     = 5;
   localparam int          BS_RX_A_PAR     = 6;
   localparam int          BS_RX_B_PAR     = 7;
   // control bits
   localparam int          CTRL_RX_A_LOAD  = 0;
   localparam int          CTRL_RX_B_LOAD  = 1;
   localparam int          CTRL_TX_A_LOAD  = 2;
   localparam int          CTRL_TX_B_LOAD  = 3;
   localparam int          CTRL_RX_RST     = 4;
   localparam int          CTRL_TX_RST     = 5;
   // interrupt bits
   localparam int          IRQ_TX_A_DONE   = 0;
   localparam int          IRQ_TX_B_DONE   = 1;
   localparam int          IRQ_RX_A_DONE   = 2;
   localparam int          IRQ_RX_B_DONE   = 3;
   localparam int          IRQ_OVERRUN     = 4;
   localparam int          IRQ_PARITY      = 5;
   localparam int          CFG_UART        = 0;
   typedef enum logic [1:0] {FETCH_IDLE, FETCH_ASK, FETCH_WAIT} fetch_state_t;
endpackage

// [test/dma_status_asserts.sv]
// port checks of the dma status block
`timescale 1ns/10ps
module dma_status_asserts
   import dma_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [31:0]       avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              mem_rd_req,
   input wire logic [ADDR_W-1:0] mem_rd_addr,
   input wire logic              mem_rd_ack,
   input wire logic [7:0]        mem_rd_data,
   input wire logic [7:0]        tx_data,
   input wire logic              tx_data_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // steps of a read answer and of a byte fetch
   sequence s_rd;
      avs_read && !avs_waitrequest;
   endsequence
   sequence s_fetch;
      mem_rd_req && mem_rd_ack;
   endsequence
   sequence s_byte;
      tx_data_valid && tx_data == $past(mem_rd_data) ##1 !tx_data_valid;
   endsequence
   AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("late answer");
   AST_ADDR_UPPER: assert property (
      s_rd and avs_address[31:4] == TX_A_START_OFS[31:4] |->
      avs_readdata[31:14] == TX_ADDR_FIXED[31:14]) else $error("upper bits");
   AST_OFFSET_UPPER: assert property (
      s_rd and avs_address == TX_OFFSET_OFS |-> avs_readdata[31:14] == 18'h0)
      else $error("offset bits");
   AST_STATE_UPPER: assert property (
      s_rd and avs_address == BUF_STATE_OFS |-> avs_readdata[31:8] == 24'h0)
      else $error("state bits");
   AST_CTRL_SELF_CLR: assert property (
      s_rd and avs_address == CTRL_OFS |-> avs_readdata[31:4] == 28'h0)
      else $error("reset bits");
   AST_UNMAPPED_ZERO: assert property (
      s_rd and avs_address == 32'h4000c840 |-> avs_readdata == 32'h0)
      else $error("unmapped");
   AST_FETCH_TO_BYTE: assert property (s_fetch |=> s_byte)
      else $error("lost byte");
   AST_BYTE_HAS_CAUSE: assert property (
      tx_data_valid |-> $past(mem_rd_req && mem_rd_ack)) else $error("no fetch");
   AST_REQ_HOLD: assert property (
      mem_rd_req && !mem_rd_ack |=> !mem_rd_req || $stable(mem_rd_addr))
      else $error("addr moved");
endmodule

// [test/fifo_ram_model.sv]
// far side: receive fifo, system ram and transmit fifo room
`timescale 1ns/10ps
module fifo_ram_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        slow,
   input  wire logic        stall,
   input  wire logic        push,
   input  wire logic        push_par,
   input  wire logic        rx_byte_ready,
   output logic             rx_byte_valid,
   output logic             rx_byte_parity_err,
   output logic             rx_fifo_full,
   input  wire logic        mem_rd_req,
   input  wire logic [13:0] mem_rd_addr,
   output logic             mem_rd_ack,
   output logic [7:0]       mem_rd_data,
   output logic             tx_data_ready
);
   logic [2:0] cnt, c_n;
   logic [3:0] par, p_n;
   logic [4:0] wait_n;
   logic       tgl;
   function automatic logic [7:0] mem_byte(input logic [13:0] a);
      return a[7:0] ^ {a[13:8], 2'b01};
   endfunction
   // four-deep rx fifo of parity marks
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 3'd0;
         par <= 4'h0;
      end else begin
         p_n = par;
         c_n = cnt;
         if (rx_byte_valid && rx_byte_ready) begin
            p_n = par >> 1;
            c_n = cnt - 3'd1;
         end
         if (push && c_n < 3'd4) begin
            p_n[c_n[1:0]] = push_par;
            c_n = c_n + 3'd1;
         end
         cnt <= c_n;
         par <= p_n;
      end
   end
   assign rx_fifo_full       = cnt == 3'd4;
   assign rx_byte_valid      = cnt != 3'd0;
   assign rx_byte_parity_err = rx_byte_valid ? par[0] : tgl;
   assign tx_data_ready      = !stall;
   // ram answers after a short or a long wait
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_rd_ack <= 1'b0;
         wait_n     <= 5'd1;
         tgl        <= 1'b0;
      end else begin
         tgl        <= !tgl;
         mem_rd_ack <= 1'b0;
         if (mem_rd_req && !mem_rd_ack) begin
            if (wait_n == 5'd0) begin
               mem_rd_ack <= 1'b1;
               wait_n     <= slow ? 5'd9 : 5'($urandom_range(2));
            end else begin
               wait_n <= wait_n - 5'd1;
            end
         end
      end
   end
   assign mem_rd_data = mem_rd_ack ? mem_byte(mem_rd_addr) : {8{tgl}};
endmodule

// [test/serial_dual_buffer_dma_status_tb.sv]
// self-checking bench of the dma status block
`timescale 1ns/10ps
bind serial_dma_status dma_status_asserts chk (.clk, .rstn, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .mem_rd_req, .mem_rd_addr, .mem_rd_ack,
   .mem_rd_data, .tx_data, .tx_data_valid);
module serial_dual_buffer_dma_status_tb;
   import dma_pkg::*;
   logic        clk, rstn, avs_read, avs_write, avs_waitrequest, irq, rx_buf_end;
   logic        rx_byte_valid, rx_byte_parity_err, rx_byte_ready, rx_fifo_full;
   logic        mem_rd_req, mem_rd_ack, tx_data_valid, tx_data_ready;
   logic        slow, stall, push, push_par;
   logic [31:0] avs_address, avs_writedata, avs_readdata, rd_v, v, m_v, e_v;
   logic [3:0]  avs_byteenable;
   logic [13:0] mem_rd_addr, sa, sb;
   logic [7:0]  mem_rd_data, tx_data;
   logic [63:0] rq_q[$];
   logic [7:0]  tx_q[$];
   logic [31:0] ar[4] = '{TX_A_START_OFS, TX_A_LAST_OFS, TX_B_START_OFS, TX_B_LAST_OFS};
   int          n_mismatch, num_checks, k;
   serial_dma_status dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .rx_byte_valid,
      .rx_byte_parity_err, .rx_byte_ready, .rx_fifo_full, .rx_buf_end, .mem_rd_req,
      .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .tx_data, .tx_data_valid, .tx_data_ready);
   fifo_ram_model m (.clk, .rstn, .slow, .stall, .push, .push_par, .rx_byte_ready,
      .rx_byte_valid, .rx_byte_parity_err, .rx_fifo_full, .mem_rd_req, .mem_rd_addr,
      .mem_rd_ack, .mem_rd_data, .tx_data_ready);
   task automatic cmp(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one avalon transfer, held until waitrequest low
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !w;
      avs_write     <= w;
      @(negedge clk);
      while (avs_waitrequest !== 1'b0) @(negedge clk);
      rd_v = avs_readdata;
      @(posedge clk);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, e, msk);
      rq_q.push_back({msk, e});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic poll(input logic [31:0] a, msk);
      do bus(1'b0, a, 32'h0);
      while ((rd_v & msk) != 32'h0);
   endtask
   task automatic fill(input int n, input logic p);
      repeat (n) begin
         @(posedge clk);
         push     <= 1'b1;
         push_par <= p;
      end
      @(posedge clk);
      push <= 1'b0;
   endtask
   task automatic drain;
      wait (!rx_byte_valid);
   endtask
   // compare reads and sent bytes
   always @(negedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0 && rq_q.size() > 0) begin
         {m_v, e_v} = rq_q.pop_front();
         cmp("readdata", e_v & m_v, avs_readdata & m_v);
      end
      if (tx_data_valid === 1'b1)
         cmp("tx_data", tx_q.size() > 0 ? {24'h0, tx_q.pop_front()} : 32'hx, {24'h0, tx_data});
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {rstn, avs_read, avs_write, rx_buf_end, slow, stall, push, push_par} = 8'h00;
      {avs_address, avs_writedata, avs_byteenable} = {64'h0, 4'hf};
      n_mismatch = 0;
      num_checks = 0;
      void'($urandom(12713));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (k = 0; k < 4; k++) rd(ar[k], TX_ADDR_FIXED, '1);
      rd(TX_OFFSET_OFS, 32'h0, '1);
      rd(BUF_STATE_OFS, 32'h0, '1);
      rd(32'h4000c840, 32'h0, '1);
      for (k = 0; k < 4; k++) begin
         v = $urandom();
         wr(ar[k], v);
         rd(ar[k], TX_ADDR_FIXED | v[13:0], '1);
      end
      // a and b loaded together, a first
      sa = 14'($urandom());
      sb = 14'($urandom());
      wr(TX_A_START_OFS, {18'h0, sa});
      wr(TX_A_LAST_OFS, {18'h0, 14'(sa + 14'd2)});
      wr(TX_B_START_OFS, {18'h0, sb});
      wr(TX_B_LAST_OFS, {18'h0, 14'(sb + 14'd1)});
      for (k = 0; k < 3; k++) tx_q.push_back(m.mem_byte(14'(sa + k)));
      for (k = 0; k < 2; k++) tx_q.push_back(m.mem_byte(14'(sb + k)));
      stall <= 1'b1;
      wr(CTRL_OFS, 32'hc);
      rd(CTRL_OFS, 32'hc, 32'h3f);
      rd(BUF_STATE_OFS, 32'h4, 32'hf);
      rd(TX_OFFSET_OFS, 32'h0, '1);
      stall <= 1'b0;
      poll(CTRL_OFS, 32'h4);
      slow <= 1'b1;
      poll(CTRL_OFS, 32'h8);
      rd(BUF_STATE_OFS, 32'h0, 32'hf);
      cmp("irq", 32'h0, {31'h0, irq});
      wr(IRQ_MASK_OFS, 32'h3);
      @(negedge clk);
      cmp("irq", 32'h1, {31'h0, irq});
      rd(IRQ_STATUS_OFS, 32'h3, 32'h3);
      @(negedge clk);
      cmp("irq", 32'h0, {31'h0, irq});
      // reload, then reset mid-fetch
      wr(CTRL_OFS, 32'h4);
      rd(TX_OFFSET_OFS, 32'h0, '1);
      for (k = 0; k < 40 && mem_rd_req !== 1'b1; k++) @(posedge clk);
      wr(CTRL_OFS, 32'h20);
      rd(TX_OFFSET_OFS, 32'h0, '1);
      rd(CTRL_OFS, 32'h0, 32'h30);
      repeat (20) @(posedge clk);
      // overrun passes to next loaded buffer
      wr(CONFIG_OFS, 32'h1);
      fill(4, 1'b0);
      wr(CTRL_OFS, 32'h2);
      drain();
      rd(BUF_STATE_OFS, 32'h22, 32'h3f);
      @(posedge clk);
      rx_buf_end <= 1'b1;
      @(posedge clk);
      rx_buf_end <= 1'b0;
      wr(CTRL_OFS, 32'h1);
      fill(1, 1'b1);
      drain();
      rd(BUF_STATE_OFS, 32'h61, 32'h73);
      wr(CTRL_OFS, 32'h1);
      rd(BUF_STATE_OFS, 32'h21, 32'h70);
      wr(CTRL_OFS, 32'h10);
      rd(BUF_STATE_OFS, 32'h0, 32'hf0);
      fill(4, 1'b0);
      wr(CTRL_OFS, 32'h3);
      drain();
      rd(BUF_STATE_OFS, 32'h11, 32'h33);
      cmp("tx_pending", 32'h0, 32'(tx_q.size()));
      wrap_up();
   end
endmodule
